// ==== rtl/rmfp_map.vh ====
// constants for the ring frame parser and builder
// assumes inclusion by rmfp_top.v only; rmfp_fifo.v takes its sizes as parameters
`ifndef RMFP_MAP_VH
`define RMFP_MAP_VH
// frame type codes, top two bits of frame control
`define RMFP_FT_MAC 2'h0
`define RMFP_FT_DATA 2'h1
// attention codes honoured for management frames
`define RMFP_ATT_MIN 4'h1
`define RMFP_ATT_MAX 4'h6
// address layout
`define RMFP_ADDR_LAST 4'h5
`define RMFP_NODE_TAG 2'h1
`define RMFP_ALL_ONES 48'hffffffffffff
`define RMFP_ZERO_ADDR 48'h000000000000
`define RMFP_SA_NO_RI 48'h7fffffffffff
// routing field bounds
`define RMFP_RI_MAX 5'h12
`define RMFP_RI_MIN 5'h02
// information field bounds
`define RMFP_INFO_MIN 13'h0001
`define RMFP_INFO_MAX 13'h0fbb
// frame check
`define RMFP_CRC_POLY 32'h04c11db7
`define RMFP_CRC_PRESET 32'hffffffff
`define RMFP_CRC_RESIDUE 32'hc704dd7b
`define RMFP_CRC_BITS 5'h1f
// class codes
`define RMFP_CL_STATION 4'h0
`define RMFP_CL_LLC 4'h1
`define RMFP_CL_NETMGR 4'h4
`define RMFP_CL_PARAM 4'h5
`define RMFP_CL_ERRMON 4'h6
// info byte positions of major vector fields
`define RMFP_MV_LEN_HI 13'h0000
`define RMFP_MV_LEN_LO 13'h0001
`define RMFP_MAJOR_VEC_CLASS 13'h0002
`define RMFP_MV_CMD 13'h0003
`define RMFP_SV_LEN 13'h0004
`define RMFP_SUB_VEC_TYPE 13'h0005
// header bytes sent before the information field, then host fifo sizes
`define RMFP_HDR_LAST 4'hc
`define RMFP_FIFO_W 9
`define RMFP_FIFO_D 8
`define RMFP_FIFO_AW 3
`endif

// ==== rtl/rmfp_fifo.v ====
// byte fifo between ring receive logic and host side
// assumes one clock; push ignored when full, pop ignored when empty
`timescale 1ns/1ps
module rmfp_fifo #(
    parameter W = 9,
    parameter D = 8,
    parameter AW = 3
) (
    input wire clk_in,
    input wire rst_in,
    input wire [W-1:0] in_data_in,
    input wire in_valid_in,
    output wire in_ready_out,
    output wire [W-1:0] out_data_out,
    output wire out_valid_out,
    input wire out_ready_in
);
    reg [AW:0] wp_reg;
    reg [AW:0] rp_reg;
    reg [W-1:0] mem_reg [0:D-1];
    wire full = (wp_reg[AW] != rp_reg[AW]) &&
        (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
    wire empty = (wp_reg == rp_reg);
    wire push = in_valid_in && !full;
    wire pop = out_ready_in && !empty;
    assign in_ready_out = !full;
    assign out_valid_out = !empty;
    assign out_data_out = mem_reg[rp_reg[AW-1:0]];
    //==========================================
    // storage
    genvar i;
    generate
        for (i = 0; i < D; i = i + 1) begin : g_ent
            always @(posedge clk_in or posedge rst_in) begin
                if (rst_in)
                    mem_reg[i] <= {W{1'b0}};
                else if (push && wp_reg[AW-1:0] == i)
                    mem_reg[i] <= in_data_in;
            end
        end
    endgenerate
    //==========================================
    // pointers
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_reg <= {(AW+1){1'b0}};
            rp_reg <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wp_reg <= wp_reg + 1'b1;
            if (pop)
                rp_reg <= rp_reg + 1'b1;
        end
    end
endmodule // rmfp_fifo

// ==== rtl/rmfp_top.v ====
// ring frame field parser and builder
// assumes ring clock slow against clk_in; host ports on clk_in
// Function
// - frame type from top two control bits
// - type 00 management, 01 data, others reserved
// - built frames send control bits 4,5 zero
// - attention nibble read for management frames only
// - attention codes one to six mean express
// - target and origin addresses six bytes each
// - info field one to 4027 bytes
// - serial crc over frame, appended on send
// - received check mismatch flags copy error
// - origin top bit flags routing field
// - routing field up to 18 bytes skipped
// - group and functional bits only in target
// - byte 0 bit 1 means locally administered
// - byte 2 bit 0 marks host group
// - zero open address takes factory address
// - station address must start with 0,1
// - class byte holds target then origin nibble
// - decode the five known class codes
// - non-station target class goes to host
// - major vector length counts whole vector
// - subvector length then type then value
// - station-class management frames withheld unless passing requested
// - own frames carry own station address
`include "rmfp_map.vh"
`timescale 1ns/1ps
module rmfp_top (
    input wire clk_in,
    input wire rst_in,
    input wire ring_clk_in,
    input wire ring_data_in,
    input wire ring_frame_in,
    output reg ring_tx_data_out,
    output reg ring_tx_frame_out,
    input wire open_in,
    input wire [47:0] host_addr_in,
    input wire [47:0] factory_addr_in,
    input wire [47:0] group_addr_in,
    input wire pass_mac_in,
    output reg [47:0] station_addr_out,
    output reg node_addr_err_out,
    output reg open_done_out,
    output reg rx_done_out,
    output reg [1:0] rx_type_out,
    output reg [3:0] attention_out,
    output reg express_out,
    output reg copy_err_out,
    output reg len_err_out,
    output reg ri_present_out,
    output reg ri_err_out,
    output reg tgt_group_out,
    output reg tgt_host_group_out,
    output reg tgt_local_out,
    output reg org_local_out,
    output reg [3:0] tgt_class_out,
    output reg [3:0] org_class_out,
    output reg class_known_out,
    output reg tgt_station_out,
    output reg [15:0] mv_len_out,
    output reg mv_len_err_out,
    output reg [7:0] mv_cmd_out,
    output reg [7:0] sv_len_out,
    output reg [7:0] sub_vec_type_out,
    output reg overrun_out,
    output reg [7:0] host_data_out,
    output reg host_marker_out,
    output reg host_valid_out,
    input wire host_ready_in,
    input wire tx_start_in,
    input wire [7:0] tx_fc_in,
    input wire [47:0] tx_target_in,
    input wire [7:0] tx_byte_in,
    input wire tx_byte_valid_in,
    input wire tx_byte_last_in,
    output reg tx_byte_ready_out,
    output reg tx_busy_out
);
    localparam R_IDLE = 3'h0;
    localparam R_FC = 3'h1;
    localparam R_DA = 3'h2;
    localparam R_SA = 3'h3;
    localparam R_RI = 3'h4;
    localparam R_PAY = 3'h5;
    localparam T_IDLE = 2'h0;
    localparam T_HDR = 2'h1;
    localparam T_INFO = 2'h2;
    localparam T_CRC = 2'h3;

    function known_class;
        input [3:0] c;
        begin
            known_class = (c == `RMFP_CL_STATION) || (c == `RMFP_CL_LLC) ||
                (c == `RMFP_CL_NETMGR) || (c == `RMFP_CL_PARAM) ||
                (c == `RMFP_CL_ERRMON);
        end
    endfunction

    function [31:0] crc_bit;
        input [31:0] c;
        input b;
        begin
            crc_bit = {c[30:0], 1'b0} ^
                ((c[31] ^ b) ? `RMFP_CRC_POLY : 32'h00000000);
        end
    endfunction

    //==========================================
    // pin synchronisers and ring clock edges
    reg [2:0] sy1_reg;
    reg [2:0] sy2_reg;
    reg rck_d_reg;
    reg frm_d_reg;
    wire rck = sy2_reg[2];
    wire rdat = sy2_reg[1];
    wire rfrm = sy2_reg[0];
    wire rise = rck && !rck_d_reg;
    wire fall = !rck && rck_d_reg;
    wire f_start = rfrm && !frm_d_reg;
    wire f_end = !rfrm && frm_d_reg;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sy1_reg <= 3'h0;
            sy2_reg <= 3'h0;
            rck_d_reg <= 1'b0;
            frm_d_reg <= 1'b0;
        end else begin
            sy1_reg <= {ring_clk_in, ring_data_in, ring_frame_in};
            sy2_reg <= sy1_reg;
            rck_d_reg <= sy2_reg[2];
            frm_d_reg <= sy2_reg[0];
        end
    end

    //==========================================
    // receive path
    reg [2:0] rst_reg;
    reg [6:0] sh_reg;
    reg [2:0] bcnt_reg;
    reg [7:0] byte_reg;
    reg stb_reg;
    reg [31:0] rcrc_reg;
    reg [4:0] cnt_reg;
    reg [4:0] ri_len_reg;
    reg [47:0] da_reg;
    reg [47:0] sa_reg;
    reg [7:0] fc_reg;
    reg [31:0] dl_reg;
    reg [2:0] dcnt_reg;
    reg [12:0] info_reg;
    reg [23:0] hold_reg;
    reg [1:0] pend_reg;
    reg fwd_reg;
    reg [47:0] group_reg;
    wire mac = (fc_reg[7:6] == `RMFP_FT_MAC);
    wire emit = stb_reg && (rst_reg == R_PAY) && (dcnt_reg[2]);
    wire [7:0] ebyte = dl_reg[31:24];
    wire copied = (da_reg == station_addr_out) || (da_reg == group_reg) ||
        (da_reg == `RMFP_ALL_ONES);
    wire [7:0] cls = ebyte;
    wire mac_fwd = copied &&
        ((cls[7:4] != `RMFP_CL_STATION) || pass_mac_in);
    wire fifo_rdy;
    wire live_push = emit && fwd_reg && !(mac && info_reg <= `RMFP_MAJOR_VEC_CLASS);
    wire end_push = f_end && fwd_reg;
    wire push_v = (pend_reg != 2'h0) || live_push || end_push;
    wire end_crc_bad = (rcrc_reg != `RMFP_CRC_RESIDUE);
    wire end_len_bad = (info_reg < `RMFP_INFO_MIN) ||
        (info_reg > `RMFP_INFO_MAX);
    wire [7:0] end_stat = {3'h0, overrun_out, ri_err_out,
        mac && (mv_len_out != {3'h0, info_reg}), end_len_bad, end_crc_bad};
    wire [8:0] push_d = (pend_reg != 2'h0) ? {1'b0, hold_reg[23:16]} :
        (end_push ? {1'b1, end_stat} : {1'b0, ebyte});

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rst_reg <= R_IDLE;
            sh_reg <= 7'h00;
            bcnt_reg <= 3'h0;
            byte_reg <= 8'h00;
            stb_reg <= 1'b0;
            rcrc_reg <= `RMFP_CRC_PRESET;
            cnt_reg <= 5'h00;
            ri_len_reg <= 5'h00;
            da_reg <= 48'h000000000000;
            sa_reg <= 48'h000000000000;
            fc_reg <= 8'h00;
            dl_reg <= 32'h00000000;
            dcnt_reg <= 3'h0;
            info_reg <= 13'h0000;
            hold_reg <= 24'h000000;
            pend_reg <= 2'h0;
            fwd_reg <= 1'b0;
            rx_done_out <= 1'b0;
            rx_type_out <= 2'h0;
            attention_out <= 4'h0;
            express_out <= 1'b0;
            copy_err_out <= 1'b0;
            len_err_out <= 1'b0;
            ri_present_out <= 1'b0;
            ri_err_out <= 1'b0;
            tgt_group_out <= 1'b0;
            tgt_host_group_out <= 1'b0;
            tgt_local_out <= 1'b0;
            org_local_out <= 1'b0;
            tgt_class_out <= 4'h0;
            org_class_out <= 4'h0;
            class_known_out <= 1'b0;
            tgt_station_out <= 1'b0;
            mv_len_out <= 16'h0000;
            mv_len_err_out <= 1'b0;
            mv_cmd_out <= 8'h00;
            sv_len_out <= 8'h00;
            sub_vec_type_out <= 8'h00;
            overrun_out <= 1'b0;
        end else begin
            stb_reg <= 1'b0;
            rx_done_out <= 1'b0;
            if (f_start) begin
                rst_reg <= R_FC;
                bcnt_reg <= 3'h0;
                rcrc_reg <= `RMFP_CRC_PRESET;
                dcnt_reg <= 3'h0;
                info_reg <= 13'h0000;
                pend_reg <= 2'h0;
                fwd_reg <= 1'b0;
                ri_err_out <= 1'b0;
                overrun_out <= 1'b0;
                mv_len_out <= 16'h0000;
            end else if (rfrm && rise && rst_reg != R_IDLE) begin
                sh_reg <= {sh_reg[5:0], rdat};
                bcnt_reg <= bcnt_reg + 1'b1;
                rcrc_reg <= crc_bit(rcrc_reg, rdat);
                if (bcnt_reg == 3'h7) begin
                    byte_reg <= {sh_reg, rdat};
                    stb_reg <= 1'b1;
                end
            end
            if (stb_reg) begin
                case (rst_reg)
                R_FC: begin
                    fc_reg <= byte_reg;
                    rx_type_out <= byte_reg[7:6];
                    attention_out <= (byte_reg[7:6] == `RMFP_FT_MAC) ?
                        byte_reg[3:0] : 4'h0;
                    express_out <= (byte_reg[7:6] == `RMFP_FT_MAC) &&
                        (byte_reg[3:0] >= `RMFP_ATT_MIN) &&
                        (byte_reg[3:0] <= `RMFP_ATT_MAX);
                    cnt_reg <= 5'h00;
                    rst_reg <= R_DA;
                end
                R_DA: begin
                    da_reg <= {da_reg[39:0], byte_reg};
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg[3:0] == `RMFP_ADDR_LAST) begin
                        cnt_reg <= 5'h00;
                        rst_reg <= R_SA;
                    end
                end
                R_SA: begin
                    sa_reg <= {sa_reg[39:0], byte_reg};
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg[3:0] == `RMFP_ADDR_LAST) begin
                        cnt_reg <= 5'h00;
                        rst_reg <= sa_reg[39] ? R_RI : R_PAY;
                        ri_present_out <= sa_reg[39];
                        org_local_out <= sa_reg[38];
                        tgt_group_out <= da_reg[47];
                        tgt_host_group_out <= da_reg[47] && da_reg[31];
                        tgt_local_out <= da_reg[46];
                        fwd_reg <= copied && !mac;
                    end
                end
                R_RI: begin
                    cnt_reg <= cnt_reg + 1'b1;
                    if (cnt_reg == 5'h00) begin
                        ri_len_reg <= byte_reg[4:0];
                        ri_err_out <= (byte_reg[4:0] > `RMFP_RI_MAX) ||
                            (byte_reg[4:0] < `RMFP_RI_MIN) || byte_reg[0];
                        if (byte_reg[4:0] < `RMFP_RI_MIN)
                            rst_reg <= R_PAY;
                    end else if (cnt_reg + 1'b1 == ri_len_reg) begin
                        rst_reg <= R_PAY;
                    end
                end
                R_PAY: begin
                    dl_reg <= {dl_reg[23:0], byte_reg};
                    if (!dcnt_reg[2])
                        dcnt_reg <= dcnt_reg + 1'b1;
                end
                default: rst_reg <= R_IDLE;
                endcase
            end
            if (emit) begin
                if (info_reg != `RMFP_INFO_MAX + 1'b1)
                    info_reg <= info_reg + 1'b1;
                if (mac) begin
                    if (info_reg <= `RMFP_MAJOR_VEC_CLASS)
                        hold_reg <= {hold_reg[15:0], ebyte};
                    if (info_reg == `RMFP_MV_LEN_HI)
                        mv_len_out[15:8] <= ebyte;
                    if (info_reg == `RMFP_MV_LEN_LO)
                        mv_len_out[7:0] <= ebyte;
                    if (info_reg == `RMFP_MAJOR_VEC_CLASS) begin
                        tgt_class_out <= cls[7:4];
                        org_class_out <= cls[3:0];
                        class_known_out <= known_class(cls[7:4]) &&
                            known_class(cls[3:0]);
                        tgt_station_out <= (cls[7:4] == `RMFP_CL_STATION);
                        fwd_reg <= mac_fwd;
                        if (mac_fwd)
                            pend_reg <= 2'h3;
                    end
                    if (info_reg == `RMFP_MV_CMD)
                        mv_cmd_out <= ebyte;
                    if (info_reg == `RMFP_SV_LEN)
                        sv_len_out <= ebyte;
                    if (info_reg == `RMFP_SUB_VEC_TYPE)
                        sub_vec_type_out <= ebyte;
                end
            end
            if (pend_reg != 2'h0 && fifo_rdy) begin
                pend_reg <= pend_reg - 1'b1;
                hold_reg <= {hold_reg[15:0], 8'h00};
            end
            if (push_v && !fifo_rdy)
                overrun_out <= 1'b1;
            if (f_end && rst_reg != R_IDLE) begin
                rst_reg <= R_IDLE;
                rx_done_out <= 1'b1;
                copy_err_out <= end_crc_bad;
                len_err_out <= end_len_bad;
                mv_len_err_out <= mac && (mv_len_out != {3'h0, info_reg});
            end
        end
    end

    //==========================================
    // host delivery
    wire [8:0] fifo_d;
    wire fifo_v;
    wire fifo_pop = fifo_v && (!host_valid_out || host_ready_in);
    rmfp_fifo #(
        .W(`RMFP_FIFO_W),
        .D(`RMFP_FIFO_D),
        .AW(`RMFP_FIFO_AW)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_data_in(push_d),
        .in_valid_in(push_v),
        .in_ready_out(fifo_rdy),
        .out_data_out(fifo_d),
        .out_valid_out(fifo_v),
        .out_ready_in(fifo_pop)
    );
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            host_data_out <= 8'h00;
            host_marker_out <= 1'b0;
            host_valid_out <= 1'b0;
        end else if (fifo_pop) begin
            host_data_out <= fifo_d[7:0];
            host_marker_out <= fifo_d[8];
            host_valid_out <= 1'b1;
        end else if (host_ready_in) begin
            host_valid_out <= 1'b0;
        end
    end

    //==========================================
    // station address assignment
    wire [47:0] cand = (host_addr_in == `RMFP_ZERO_ADDR) ?
        factory_addr_in : host_addr_in;
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            station_addr_out <= 48'h000000000000;
            group_reg <= 48'h000000000000;
            node_addr_err_out <= 1'b0;
            open_done_out <= 1'b0;
        end else if (open_in) begin
            group_reg <= group_addr_in;
            if (cand[47:46] == `RMFP_NODE_TAG) begin
                station_addr_out <= cand;
                node_addr_err_out <= 1'b0;
                open_done_out <= 1'b1;
            end else begin
                node_addr_err_out <= 1'b1;
                open_done_out <= 1'b0;
            end
        end
    end

    //==========================================
    // transmit path
    reg [1:0] tst_reg;
    reg [103:0] hdr_reg;
    reg [3:0] tidx_reg;
    reg [2:0] tbit_reg;
    reg [6:0] tsh_reg;
    reg [31:0] tcrc_reg;
    reg [4:0] ccnt_reg;
    reg [7:0] nb_reg;
    reg nb_full_reg;
    reg nb_last_reg;
    reg [12:0] tinfo_reg;
    wire nb_take = tx_byte_ready_out && tx_byte_valid_in;
    wire [1:0] tft = tx_fc_in[7] ? `RMFP_FT_DATA : tx_fc_in[7:6];
    wire [7:0] cur = (tst_reg == T_HDR) ? hdr_reg[103:96] : nb_reg;
    wire tb = (tbit_reg == 3'h0) ? cur[7] : tsh_reg[6];
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tst_reg <= T_IDLE;
            hdr_reg <= 104'h0;
            tidx_reg <= 4'h0;
            tbit_reg <= 3'h0;
            tsh_reg <= 7'h00;
            tcrc_reg <= `RMFP_CRC_PRESET;
            ccnt_reg <= 5'h00;
            nb_reg <= 8'h00;
            nb_full_reg <= 1'b0;
            nb_last_reg <= 1'b0;
            tinfo_reg <= 13'h0000;
            tx_byte_ready_out <= 1'b0;
            tx_busy_out <= 1'b0;
            ring_tx_data_out <= 1'b0;
            ring_tx_frame_out <= 1'b0;
        end else begin
            tx_byte_ready_out <= (tst_reg == T_HDR || tst_reg == T_INFO) &&
                !nb_full_reg && !nb_take && !nb_last_reg;
            if (nb_take) begin
                nb_reg <= tx_byte_in;
                nb_full_reg <= 1'b1;
                nb_last_reg <= tx_byte_last_in;
            end
            if (tst_reg == T_IDLE) begin
                if (fall) begin
                    ring_tx_frame_out <= 1'b0; // last bit stands one bit
                    tx_busy_out <= 1'b0;
                end
                if (tx_start_in && !tx_busy_out) begin
                    hdr_reg <= {tft, 2'h0, tx_fc_in[3:0], tx_target_in,
                        station_addr_out & `RMFP_SA_NO_RI};
                    tst_reg <= T_HDR;
                    tx_busy_out <= 1'b1;
                    tidx_reg <= 4'h0;
                    tbit_reg <= 3'h0;
                    tinfo_reg <= 13'h0000;
                    tcrc_reg <= `RMFP_CRC_PRESET;
                    nb_full_reg <= 1'b0;
                    nb_last_reg <= 1'b0;
                end
            end else if (fall) begin
                ring_tx_frame_out <= 1'b1;
                if (tst_reg == T_CRC) begin
                    ring_tx_data_out <= !tcrc_reg[31];
                    tcrc_reg <= {tcrc_reg[30:0], 1'b1};
                    ccnt_reg <= ccnt_reg + 1'b1;
                    if (ccnt_reg == `RMFP_CRC_BITS)
                        tst_reg <= T_IDLE;
                end else if (tst_reg == T_INFO && tbit_reg == 3'h0 &&
                        !nb_full_reg) begin
                    ring_tx_data_out <= !tcrc_reg[31];
                    tcrc_reg <= {tcrc_reg[30:0], 1'b1};
                    ccnt_reg <= 5'h01;
                    tst_reg <= T_CRC;
                end else begin
                    ring_tx_data_out <= tb;
                    tcrc_reg <= crc_bit(tcrc_reg, tb);
                    tbit_reg <= tbit_reg + 1'b1;
                    tsh_reg <= (tbit_reg == 3'h0) ? cur[6:0] :
                        {tsh_reg[5:0], 1'b0};
                    if (tbit_reg == 3'h7) begin
                        if (tst_reg == T_HDR) begin
                            hdr_reg <= {hdr_reg[95:0], 8'h00};
                            tidx_reg <= tidx_reg + 1'b1;
                            if (tidx_reg == `RMFP_HDR_LAST)
                                tst_reg <= T_INFO;
                        end else begin
                            nb_full_reg <= nb_take;
                            tinfo_reg <= tinfo_reg + 1'b1;
                            if (nb_last_reg ||
                                    tinfo_reg + 1'b1 == `RMFP_INFO_MAX) begin
                                ccnt_reg <= 5'h00;
                                tst_reg <= T_CRC;
                            end
                        end
                    end
                end
            end
        end
    end
endmodule // rmfp_top

// ==== dv/rmfp_ring_peer.sv ====
// ring peer that repeats the adapter's frame back
// assumes tx bits are launched after the ring clock falls
`timescale 1ns/1ps
module rmfp_ring_peer (
    input wire ring_clk_in,
    input wire tx_data_in,
    input wire tx_frame_in,
    output reg rx_data_out = 0,
    output reg rx_frame_out = 0
);
    reg bit_reg = 0;
    reg frm_reg = 0;
    always @(posedge ring_clk_in) begin
        bit_reg <= tx_data_in;
        frm_reg <= tx_frame_in;
    end
    // released line toggles rather than holding
    always @(negedge ring_clk_in) begin
        rx_frame_out <= frm_reg;
        rx_data_out <= frm_reg ? bit_reg : ~rx_data_out;
    end
endmodule // rmfp_ring_peer

// ==== dv/rmfp_top_asserts.sv ====
// port checker for rmfp_top
// assumes the clk_in domain only
`timescale 1ns/1ps
module rmfp_top_asserts (
    input wire clk_in, rst_in, open_in, node_addr_err_out, open_done_out,
    input wire rx_done_out, express_out, tgt_station_out,
    input wire [1:0] rx_type_out,
    input wire [3:0] attention_out, tgt_class_out,
    input wire [47:0] host_addr_in, factory_addr_in, station_addr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    wire [47:0] pick = |host_addr_in ? host_addr_in : factory_addr_in;
    wire ok = pick[47:46] == 2'h1;
    wire mgmt = rx_done_out && !rx_type_out;
    a_attn_data: assert property (
        rx_done_out && !mgmt |-> !attention_out) else $error("attn");
    a_express_code: assert property (
        rx_done_out |-> express_out == (mgmt && attention_out inside
        {[1:6]})) else $error("express");
    a_zero_factory: assert property (
        open_in && !host_addr_in && ok |=> station_addr_out ==
        $past(factory_addr_in)) else $error("factory");
    a_bad_addr: assert property (
        open_in && !ok |=> node_addr_err_out && $stable(station_addr_out))
        else $error("bad addr");
    a_good_addr: assert property (
        open_in && ok |=> station_addr_out == $past(pick)) else $error("addr");
    a_open_done: assert property (
        open_in && ok |=> open_done_out) else $error("open");
    a_station_class: assert property (
        mgmt |-> tgt_station_out == !tgt_class_out) else $error("class");
    a_express_type: assert property (
        express_out && rx_done_out |-> mgmt) else $error("type");
    c_express: cover property (rx_done_out && express_out);
    c_data: cover property (rx_done_out && rx_type_out == 2'h1);
    c_bad: cover property (open_in && !ok);
endmodule // rmfp_top_asserts
bind rmfp_top rmfp_top_asserts chk (.*);

// ==== dv/rmfp_top_test.sv ====
// bench for rmfp_top; its frames loop back through a ring peer
// assumes host and tx ports on clk_in
`timescale 1ns/1ps
module rmfp_top_test;
    reg clk_in = 0, rst_in = 1, ring_clk_in = 0, open_in = 0;
    reg pass_mac_in = 0, host_ready_in = 0, tx_start_in = 0;
    reg tx_byte_valid_in = 0, tx_byte_last_in = 0;
    reg [7:0] tx_fc_in = 0, tx_byte_in = 0;
    reg [47:0] host_addr_in = 0, factory_addr_in = 0, group_addr_in = 0;
    reg [47:0] tx_target_in = 0;
    wire ring_data_in, ring_frame_in, ring_tx_data_out, ring_tx_frame_out;
    wire node_addr_err_out, open_done_out, rx_done_out, express_out;
    wire copy_err_out, len_err_out, ri_present_out, ri_err_out;
    wire tgt_group_out, tgt_host_group_out, tgt_local_out, org_local_out;
    wire class_known_out, tgt_station_out, mv_len_err_out, overrun_out;
    wire host_marker_out, host_valid_out, tx_byte_ready_out, tx_busy_out;
    wire [1:0] rx_type_out;
    wire [3:0] attention_out, tgt_class_out, org_class_out;
    wire [7:0] mv_cmd_out, sv_len_out, sub_vec_type_out, host_data_out;
    wire [15:0] mv_len_out;
    wire [47:0] station_addr_out;
    reg [8:0] got [$];
    integer err_count = 0, n_checks = 0, i;
    rmfp_top dut (.*);
    rmfp_ring_peer peer (.ring_clk_in, .tx_data_in(ring_tx_data_out),
        .tx_frame_in(ring_tx_frame_out), .rx_data_out(ring_data_in),
        .rx_frame_out(ring_frame_in));
    always #50 clk_in = ~clk_in;
    initial #13 forever #400 ring_clk_in = ~ring_clk_in;
    always @(posedge clk_in)
        if (host_valid_out === 1'b1 && host_ready_in)
            got.push_back({host_marker_out, host_data_out});
    task chk(input [63:0] s, e);
        n_checks = n_checks + 1;
        if (s !== e) begin
            err_count = err_count + 1;
            $display("mismatch %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task do_open(input [47:0] h, f);
        @(posedge clk_in);
        host_addr_in <= h;
        factory_addr_in <= f;
        open_in <= 1;
        @(posedge clk_in);
        open_in <= 0;
        @(posedge clk_in) #1;
    endtask
    task send(input [7:0] fc, input [47:0] info);
        @(posedge clk_in);
        tx_fc_in <= fc;
        tx_target_in <= station_addr_out;
        tx_start_in <= 1;
        @(posedge clk_in);
        tx_start_in <= 0;
        for (i = 0; i < 6; i = i + 1) begin
            tx_byte_in <= info[47 - 8 * i -: 8];
            tx_byte_valid_in <= 1;
            tx_byte_last_in <= i == 5;
            @(posedge clk_in);
            while (tx_byte_ready_out !== 1'b1) @(posedge clk_in);
        end
        tx_byte_valid_in <= 0;
        while (rx_done_out !== 1'b1) @(posedge clk_in);
        #1;
    endtask
    task t_open;
        do_open(48'hc00000000001, 0);
        chk({node_addr_err_out, station_addr_out}, 49'h1 << 48);
        do_open(0, 48'h400000000012);
        chk({open_done_out, station_addr_out}, 49'h1400000000012);
    endtask
    // host stalls through the frame, then drains
    task t_data;
        send(8'hf1, 48'h111213141516);
        chk({rx_type_out, attention_out, express_out}, 7'h20);
        chk({copy_err_out, len_err_out, ri_present_out}, 0);
        @(posedge clk_in) host_ready_in <= 1;
        repeat (40) @(posedge clk_in);
        chk(got.size(), 7);
        for (i = 0; i < 7; i = i + 1)
            chk(got[i], i < 6 ? 8'h11 + i : 9'h100);
    endtask
    task t_mgmt;
        got.delete();
        send(8'h02, 48'h000604020207);
        chk({rx_type_out, attention_out, express_out}, 7'h05);
        chk({tgt_class_out, org_class_out, mv_len_out, mv_cmd_out,
            sv_len_out, sub_vec_type_out}, 48'h040006020207);
        chk({tgt_group_out, tgt_host_group_out, tgt_local_out, org_local_out,
            class_known_out, mv_len_err_out, ri_err_out, overrun_out,
            tx_busy_out, ring_tx_frame_out}, 10'h0e0);
        repeat (40) @(posedge clk_in);
        chk({got.size(), tgt_station_out, copy_err_out}, 2);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 0;
        repeat (2) @(posedge clk_in);
        t_open;
        t_data;
        t_mgmt;
        test_done;
    end
    initial begin
        repeat (9000) @(posedge clk_in);
        err_count = err_count + 1;
        test_done;
    end
endmodule // rmfp_top_test
